// [rtc_alarm_and_config_regs.sv]
// alarm comparators, output pin select, array guard, trim and supply regs
`include "rtc_consts.svh"
module rtc_alarm_and_config_regs
#(
    parameter logic [2:0] RESET_LEVEL_DEFAULT = 3'h0
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic osc_pin,
    input wire logic on_battery,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic wr_end,
    input wire logic sr_read_done,
    input rtc_pkg::time_t time_now,
    input wire logic time_upd,
    input wire logic nv_wr_req,
    input wire logic [8:0] nv_wr_addr,
    output logic nv_wr_grant,
    input wire logic nv_restore,
    input rtc_pkg::nv_image_t nv_image_in,
    output rtc_pkg::nv_image_t nv_image_out,
    output logic sec_tick,
    output logic pin_o,
    output logic pin_oe_n,
    output logic [5:0] load_cap_code,
    output logic [7:0] cx_half_pf,
    output logic rate_sign,
    output logic [1:0] rate_mag,
    output logic serial_enable,
    output logic switchover_policy,
    output logic [2:0] reset_level,
    output logic reset_level_valid
);
    rtc_pkg::core_t st_r;
    rtc_pkg::core_t st_nxt;
    rtc_pkg::alarm_set_t set0;
    rtc_pkg::alarm_set_t set1;
    logic hit0;
    logic hit1;
    logic osc_level;
    logic osc_tick;
    logic fout_4k;
    logic fout_1hz;
    logic alarm0_irq_en;
    logic alarm1_irq_en;
    logic repeat_pulse_mode;
    logic alarm_route;
    logic irq_act;
    logic [3:0] slot;

    // pick the six compared bytes of one alarm set out of the store
    function automatic rtc_pkg::alarm_set_t alarm_set(
        input rtc_pkg::alarm_mem_t m,
        input logic idx);
        alarm_set.sec = m[{idx, `ALM_SEC}];
        alarm_set.min = m[{idx, `ALM_MIN}];
        alarm_set.hour = m[{idx, `ALM_HOUR}];
        alarm_set.date = m[{idx, `ALM_DATE}];
        alarm_set.month = m[{idx, `ALM_MONTH}];
        alarm_set.dow = m[{idx, `ALM_DOW}];
    endfunction

    // which guard code covers an array location
    function automatic logic guarded(input logic [2:0] s,
                                     input logic [8:0] a);
        unique case (s)
            3'h0: guarded = 1'b0;
            3'h1: guarded = a >= `GUARD_QTR;
            3'h2: guarded = a >= `GUARD_HALF;
            3'h3: guarded = 1'b1;
            3'h4: guarded = a <= `GUARD_P4;
            3'h5: guarded = a <= `GUARD_P8;
            3'h6: guarded = a <= `GUARD_P16;
            3'h7: guarded = 1'b1;
        endcase
    endfunction

    assign set0 = alarm_set(st_r.nv.alarm, 1'b0);
    assign set1 = alarm_set(st_r.nv.alarm, 1'b1);
    assign slot = reg_addr[3:0];

    alarm_match u_match0
    (
        .set(set0),
        .now(time_now),
        .hit(hit0)
    );

    alarm_match u_match1
    (
        .set(set1),
        .now(time_now),
        .hit(hit1)
    );

    rate_gen u_rate
    (
        .clk(clk),
        .reset(reset),
        .osc_pin(osc_pin),
        .rate_sign(st_r.nv.cfg.dtr[2]),
        .rate_ten(st_r.nv.cfg.dtr[1]),
        .rate_twenty(st_r.nv.cfg.dtr[0]),
        .osc_level(osc_level),
        .osc_tick(osc_tick),
        .fout_4k(fout_4k),
        .fout_1hz(fout_1hz),
        .sec_tick(sec_tick)
    );

    // control fields of the pin register
    assign repeat_pulse_mode = st_r.nv.cfg.pin[7];
    assign alarm1_irq_en = st_r.nv.cfg.pin[6];
    assign alarm0_irq_en = st_r.nv.cfg.pin[5];
    assign alarm_route = st_r.nv.cfg.pin[4:3] == 2'b00;

    // a pulse is cut short if both enables drop, so the pin never sticks
    assign irq_act = alarm_route & (repeat_pulse_mode
        ? st_r.pulse_on & (alarm0_irq_en | alarm1_irq_en)
        : (st_r.al0 & alarm0_irq_en)
          | (st_r.al1 & alarm1_irq_en));

    always_comb
    begin
        st_nxt = st_r;
        // battery sense is a pin: three stages, counted once two agree
        st_nxt.bat_sync = {st_r.bat_sync[1:0], on_battery};
        if (st_r.bat_sync[1] == st_r.bat_sync[2])
            st_nxt.bat_stable = st_r.bat_sync[2];
        st_nxt.serial_en = !(st_r.nv.cfg.supply_switch_cfg[7] & st_r.bat_stable);

        // status byte: arm and disarm of the two write latches
        if (reg_wr && reg_addr == `ADDR_STATUS)
        begin
            if (reg_wdata == `SR_DISARM)
            begin
                st_nxt.write_latch = 1'b0;
                st_nxt.reg_write_latch = 1'b0;
            end
            else if (reg_wdata == `SR_ARM_WEL)
                st_nxt.write_latch = 1'b1;
            else if (reg_wdata == `SR_ARM_BOTH && st_r.write_latch)
                st_nxt.reg_write_latch = 1'b1;
        end
        // alarm and control writes only land while the latch is armed
        else if (reg_wr && st_r.reg_write_latch)
        begin
            if (reg_addr < `ADDR_GUARD)
            begin
                // the year slot has no storage
                if (slot[2:0] != `ALM_YEAR)
                begin
                    st_nxt.nv.alarm[slot] = reg_wdata;
                    st_nxt.wr_dirty = 1'b1;
                end
            end
            else
            begin
                st_nxt.wr_dirty = 1'b1;
                unique case (reg_addr)
                    `ADDR_GUARD: st_nxt.nv.cfg.guard = reg_wdata & `MASK_GUARD;
                    `ADDR_PIN: st_nxt.nv.cfg.pin = reg_wdata & `MASK_PIN;
                    `ADDR_ATR: st_nxt.nv.cfg.analog_cap_tune = reg_wdata & `MASK_ATR;
                    `ADDR_DTR: st_nxt.nv.cfg.dtr = reg_wdata & `MASK_DTR;
                    // no guard code covers the reset level
                    `ADDR_PWR: st_nxt.nv.cfg.supply_switch_cfg = reg_wdata & `MASK_PWR;
                    default: st_nxt.wr_dirty = st_r.wr_dirty;
                endcase
            end
        end
        // the latch disarms at the end of a transfer that changed a reg
        if (wr_end && st_r.wr_dirty)
        begin
            st_nxt.reg_write_latch = 1'b0;
            st_nxt.wr_dirty = 1'b0;
        end
        // restore from backing store wins over any write in flight
        if (nv_restore)
            st_nxt.nv = nv_image_in;

        // flags: a status read clears, a match in the same cycle wins
        if (sr_read_done)
        begin
            st_nxt.al0 = 1'b0;
            st_nxt.al1 = 1'b0;
        end
        if (time_upd && hit0)
            st_nxt.al0 = 1'b1;
        if (time_upd && hit1)
            st_nxt.al1 = 1'b1;

        // repeat mode: every match of an alarm with its irq enable set restarts a fixed low pulse
        if (time_upd && repeat_pulse_mode
            && ((hit0 && alarm0_irq_en) || (hit1 && alarm1_irq_en)))
        begin
            st_nxt.pulse_on = 1'b1;
            st_nxt.pulse_cnt = 14'h0000;
        end
        else if (st_r.pulse_on && osc_tick)
        begin
            if (st_r.pulse_cnt == 14'(`IRQ_PULSE_TICKS - 1))
                st_nxt.pulse_on = 1'b0;
            else
                st_nxt.pulse_cnt = st_r.pulse_cnt + 14'h0001;
        end

        // shared pin: alarm is open drain, clock outputs are driven
        unique case (rtc_pkg::fout_sel_t'(st_r.nv.cfg.pin[4:3]))
            rtc_pkg::FOUT_ALARM:
            begin
                st_nxt.pin_o = 1'b0;
                st_nxt.pin_oe_n = !irq_act;
            end
            rtc_pkg::FOUT_32K:
            begin
                st_nxt.pin_o = osc_level;
                st_nxt.pin_oe_n = 1'b0;
            end
            rtc_pkg::FOUT_4K:
            begin
                st_nxt.pin_o = fout_4k;
                st_nxt.pin_oe_n = 1'b0;
            end
            rtc_pkg::FOUT_1HZ:
            begin
                st_nxt.pin_o = fout_1hz;
                st_nxt.pin_oe_n = 1'b0;
            end
        endcase

        // guard check on a write into the array
        st_nxt.grant = nv_wr_req
                       && !guarded(st_r.nv.cfg.guard[7:5], nv_wr_addr);

        // half-pF units, so the 0.5 pF weight stays an integer
        st_nxt.cx_half_pf = 8'({~st_r.nv.cfg.analog_cap_tune[5], st_r.nv.cfg.analog_cap_tune[4:0]})
                            + `CX_BASE_HALF_PF;
        st_nxt.rst_valid = st_r.nv.cfg.supply_switch_cfg[2:0] <= `VTS_LAST;

        // read data, taken on the read strobe
        if (reg_rd)
        begin
            if (reg_addr == `ADDR_STATUS)
                st_nxt.rdata = {1'b0, st_r.al1, st_r.al0, 2'b00,
                                st_r.reg_write_latch, st_r.write_latch, 1'b0};
            else if (reg_addr < `ADDR_GUARD)
                st_nxt.rdata = (slot[2:0] == `ALM_YEAR) ? time_now.year
                                                      : st_r.nv.alarm[slot];
            else
            begin
                unique case (reg_addr)
                    `ADDR_GUARD: st_nxt.rdata = st_r.nv.cfg.guard;
                    `ADDR_PIN: st_nxt.rdata = st_r.nv.cfg.pin;
                    `ADDR_ATR: st_nxt.rdata = st_r.nv.cfg.analog_cap_tune;
                    `ADDR_DTR: st_nxt.rdata = st_r.nv.cfg.dtr;
                    `ADDR_PWR: st_nxt.rdata = st_r.nv.cfg.supply_switch_cfg;
                    default: st_nxt.rdata = 8'h00;
                endcase
            end
        end
    end

    // defaults until the backing image is restored
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_r <= '0;
            st_r.nv.cfg.guard <= `RST_GUARD;
            st_r.nv.cfg.supply_switch_cfg <= {`RST_PWR_TOP, RESET_LEVEL_DEFAULT};
            st_r.pin_oe_n <= 1'b1;
            st_r.cx_half_pf <= `CX_RESET;
            st_r.rst_valid <= 1'b1;
            st_r.serial_en <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    assign reg_rdata = st_r.rdata;
    assign nv_wr_grant = st_r.grant;
    assign nv_image_out = st_r.nv;
    assign pin_o = st_r.pin_o;
    assign pin_oe_n = st_r.pin_oe_n;
    assign load_cap_code = st_r.nv.cfg.analog_cap_tune[5:0];
    assign cx_half_pf = st_r.cx_half_pf;
    assign rate_sign = st_r.nv.cfg.dtr[2];
    assign rate_mag = st_r.nv.cfg.dtr[1:0];
    assign serial_enable = st_r.serial_en;
    assign switchover_policy = st_r.nv.cfg.supply_switch_cfg[6];
    assign reset_level = st_r.nv.cfg.supply_switch_cfg[2:0];
    assign reset_level_valid = st_r.rst_valid;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_pulse_trig;
        time_upd && hit0 && alarm0_irq_en && repeat_pulse_mode && alarm_route;
    endsequence

    sequence s_cfg_hold;
        $stable(st_r.nv.cfg.pin) [*2];
    endsequence

    a_guard_full: assert property (
        nv_wr_req && st_r.nv.cfg.guard[7:5] == 3'h3 |=> !nv_wr_grant)
        else $error("guarded write granted");
    a_guard_low: assert property (
        nv_wr_req && st_r.nv.cfg.guard[7:5] == 3'h4
        && nv_wr_addr == 9'h040 |=> nv_wr_grant)
        else $error("write above lower guard refused");
    a_flag_set: assert property (
        time_upd && hit0 |=> st_r.al0)
        else $error("alarm flag not set on match");
    a_flag_clear: assert property (
        sr_read_done && !(time_upd && hit1) |=> !st_r.al1)
        else $error("status read did not clear flag");
    a_fout_drive: assert property (
        st_r.nv.cfg.pin[4:3] != 2'b00 |=> !pin_oe_n)
        else $error("clock output not driven");
    a_irq_single: assert property (
        alarm_route && !repeat_pulse_mode && st_r.al0 && alarm0_irq_en
        |=> !pin_oe_n && !pin_o)
        else $error("single alarm not pulling pin low");
    a_irq_quiet: assert property (
        !alarm0_irq_en && !alarm1_irq_en && alarm_route |=> pin_oe_n)
        else $error("pin asserted with no enable");
    a_pulse_out: assert property (
        s_pulse_trig ##0 s_cfg_hold |-> ##2 !pin_oe_n)
        else $error("repeat alarm gave no pulse");
    a_latch_gate: assert property (
        reg_wr && reg_addr == `ADDR_DTR && !st_r.reg_write_latch && !nv_restore
        |=> $stable(st_r.nv.cfg.dtr))
        else $error("control write without armed latch");
endmodule // rtc_alarm_and_config_regs

// [rtc_consts.svh]
// register offsets, field positions, reset values and timing counts
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH
`define ADDR_GUARD 6'h10
`define ADDR_PIN 6'h11
`define ADDR_ATR 6'h12
`define ADDR_DTR 6'h13
`define ADDR_PWR 6'h14
`define ADDR_STATUS 6'h3f
`define ALM_SEC 3'h0
`define ALM_MIN 3'h1
`define ALM_HOUR 3'h2
`define ALM_DATE 3'h3
`define ALM_MONTH 3'h4
`define ALM_YEAR 3'h5
`define ALM_DOW 3'h6
`define MASK_GUARD 8'hf8
`define MASK_PIN 8'hf8
`define MASK_ATR 8'h3f
`define MASK_DTR 8'h07
`define MASK_PWR 8'hc7
`define RST_GUARD 8'h18
`define RST_PWR_TOP 5'h08
`define SR_DISARM 8'h00
`define SR_ARM_WEL 8'h02
`define SR_ARM_BOTH 8'h06
`define GUARD_QTR 9'h180
`define GUARD_HALF 9'h100
`define GUARD_P4 9'h03f
`define GUARD_P8 9'h07f
`define GUARD_P16 9'h0ff
`define CX_BASE_HALF_PF 8'h12
`define CX_RESET 8'h32
`define VTS_LAST 3'h4
`define OSC_HZ 32768
`define PPM_TEN_X100 13'h03e8
`define PPM_TWENTY_X100 13'h07d0
`define PPM_PER_COUNT_X100 13'h0bec
`define IRQ_PULSE_MS 250
`define IRQ_PULSE_TICKS (`OSC_HZ * `IRQ_PULSE_MS / 1000)
`endif

// [rtc_pkg.sv]
// shared types of the clock configuration and alarm block
package rtc_pkg;
    typedef logic [15:0][7:0] alarm_mem_t;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
        logic [7:0] dow;
    } time_t;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] dow;
    } alarm_set_t;

    typedef struct packed {
        logic [7:0] guard;
        logic [7:0] pin;
        logic [7:0] analog_cap_tune;
        logic [7:0] dtr;
        logic [7:0] supply_switch_cfg;
    } nv_cfg_t;

    typedef struct packed {
        nv_cfg_t cfg;
        alarm_mem_t alarm;
    } nv_image_t;

    typedef enum logic [1:0] {
        FOUT_ALARM = 2'b00,
        FOUT_32K = 2'b01,
        FOUT_4K = 2'b10,
        FOUT_1HZ = 2'b11
    } fout_sel_t;

    typedef struct packed {
        logic [2:0] osc_sync;
        logic osc_level;
        logic osc_tick;
        logic [2:0] div8;
        logic [15:0] sec_cnt;
        logic [12:0] acc;
        logic trim;
        logic sec_tick;
    } rate_t;

    typedef struct packed {
        nv_image_t nv;
        logic write_latch;
        logic reg_write_latch;
        logic wr_dirty;
        logic al0;
        logic al1;
        logic [2:0] bat_sync;
        logic bat_stable;
        logic [13:0] pulse_cnt;
        logic pulse_on;
        logic [7:0] rdata;
        logic grant;
        logic pin_o;
        logic pin_oe_n;
        logic [7:0] cx_half_pf;
        logic rst_valid;
        logic serial_en;
    } core_t;
endpackage

// [alarm_match.sv]
// one alarm set compared against the present time
module alarm_match
(
    input rtc_pkg::alarm_set_t set,
    input rtc_pkg::time_t now,
    output logic hit
);
    // a field with its enable clear always agrees
    function automatic logic field_ok(input logic [7:0] a,
                                      input logic [7:0] t);
        field_ok = !a[7] || (a[6:0] == t[6:0]);
    endfunction

    logic any_en;

    // no year field exists, so the year never takes part
    assign any_en = set.sec[7] | set.min[7] | set.hour[7] | set.date[7]
                    | set.month[7] | set.dow[7];
    assign hit = any_en & field_ok(set.sec, now.sec)
                 & field_ok(set.min, now.min)
                 & field_ok(set.hour, now.hour)
                 & field_ok(set.date, now.date)
                 & field_ok(set.month, now.month)
                 & field_ok(set.dow, now.dow);
endmodule // alarm_match

// [rate_gen.sv]
// oscillator sampling, frequency dividers and trimmed seconds tick
`include "rtc_consts.svh"
module rate_gen
(
    input wire logic clk,
    input wire logic reset,
    input wire logic osc_pin,
    input wire logic rate_sign,
    input wire logic rate_ten,
    input wire logic rate_twenty,
    output logic osc_level,
    output logic osc_tick,
    output logic fout_4k,
    output logic fout_1hz,
    output logic sec_tick
);
    rtc_pkg::rate_t st_r;
    rtc_pkg::rate_t st_nxt;
    logic [15:0] sec_last;
    logic [12:0] acc_sum;

    // a trimmed second is one count short (faster) or long (slower)
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.osc_tick = 1'b0;
        st_nxt.sec_tick = 1'b0;
        st_nxt.osc_sync = {st_r.osc_sync[1:0], osc_pin};
        acc_sum = st_r.acc + (rate_ten ? `PPM_TEN_X100 : 13'h0000)
                  + (rate_twenty ? `PPM_TWENTY_X100 : 13'h0000);
        sec_last = 16'(`OSC_HZ - 1);
        if (st_r.trim)
            sec_last = rate_sign ? 16'(`OSC_HZ) : 16'(`OSC_HZ - 2);
        // stage one is only seen by stage two
        if (st_r.osc_sync[1] == st_r.osc_sync[2])
        begin
            st_nxt.osc_level = st_r.osc_sync[2];
            st_nxt.osc_tick = st_r.osc_sync[2] & ~st_r.osc_level;
        end
        if (st_r.osc_tick)
        begin
            st_nxt.div8 = st_r.div8 + 3'h1;
            st_nxt.sec_cnt = st_r.sec_cnt + 16'h0001;
            if (st_r.sec_cnt >= sec_last)
            begin
                st_nxt.sec_cnt = 16'h0000;
                st_nxt.sec_tick = 1'b1;
                // a zero magnitude never builds up, so no trim either sign
                st_nxt.trim = acc_sum >= `PPM_PER_COUNT_X100;
                st_nxt.acc = st_nxt.trim ? acc_sum - `PPM_PER_COUNT_X100
                                         : acc_sum;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign osc_level = st_r.osc_level;
    assign osc_tick = st_r.osc_tick;
    assign fout_4k = st_r.div8[2];
    assign fout_1hz = |st_r.sec_cnt[15:14];
    assign sec_tick = st_r.sec_tick;
endmodule // rate_gen

// [host_model.sv]
// host model driving the register port of the clock block
module host_model
(
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [5:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic wr_end,
    output logic sr_read_done,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle bus at time zero
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        wr_end = 1'b0;
        sr_read_done = 1'b0;
    end

    // one byte write; data is scrambled once released
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // arm both latches, then one control byte, then end of transfer
    task automatic cfg(input logic [5:0] a, input logic [7:0] d);
        wr(6'h3f, 8'h02);
        wr(6'h3f, 8'h06);
        wr(a, d);
        @(posedge clk);
        wr_end <= 1'b1;
        @(posedge clk);
        wr_end <= 1'b0;
    endtask

    // read one byte; data is taken once the registered answer settles
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    // eighth clock of a status read
    task automatic status_done();
        @(posedge clk);
        sr_read_done <= 1'b1;
        @(posedge clk);
        sr_read_done <= 1'b0;
    endtask
endmodule // host_model

// [testbench.sv]
// self-checking bench of the alarm and configuration block
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic on_battery = 1'b0;
    logic nv_restore = 1'b0;
    logic [1:0] osc_div = 2'h0;
    rtc_pkg::nv_image_t nv_saved = '0;
    rtc_pkg::nv_image_t nv_out;
    logic reg_wr, reg_rd, wr_end, sr_read_done, time_upd = 1'b0;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd_val;
    rtc_pkg::time_t time_now = '0;
    logic nv_wr_req = 1'b0;
    logic [8:0] nv_wr_addr = 9'h000;
    logic nv_wr_grant, sec_tick, pin_o, pin_oe_n, rate_sign;
    logic switchover_policy, serial_enable, reset_level_valid;
    logic [5:0] load_cap_code;
    logic [7:0] cx_half_pf;
    logic [1:0] rate_mag;
    logic [2:0] reset_level;
    int err_count = 0;
    int samples_checked = 0;

    always #2 clk = ~clk;

    // oscillator stand-in at a quarter of clk, so a repeat pulse fits the run
    always @(posedge clk)
        osc_div <= osc_div + 2'h1;

    rtc_alarm_and_config_regs rtc_alarm_and_config_regs_inst (.clk(clk),
        .reset(reset), .osc_pin(osc_div[1]), .on_battery(on_battery),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .wr_end(wr_end),
        .sr_read_done(sr_read_done), .time_now(time_now),
        .time_upd(time_upd), .nv_wr_req(nv_wr_req),
        .nv_wr_addr(nv_wr_addr), .nv_wr_grant(nv_wr_grant),
        .nv_restore(nv_restore), .nv_image_in(nv_saved), .nv_image_out(nv_out),
        .sec_tick(sec_tick), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .load_cap_code(load_cap_code), .cx_half_pf(cx_half_pf),
        .rate_sign(rate_sign), .rate_mag(rate_mag),
        .serial_enable(serial_enable),
        .switchover_policy(switchover_policy),
        .reset_level(reset_level), .reset_level_valid(reset_level_valid));

    host_model host_model_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .wr_end(wr_end),
        .sr_read_done(sr_read_done), .reg_rdata(reg_rdata));

    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // protected region per guard code, worked out independently
    function automatic logic guarded(input logic [2:0] c, input logic [8:0] a);
        case (c)
            3'h1: return a >= 9'h180;
            3'h2: return a >= 9'h100;
            3'h3, 3'h7: return 1'b1;
            3'h4: return a <= 9'h03f;
            3'h5: return a <= 9'h07f;
            3'h6: return a <= 9'h0ff;
            default: return 1'b0;
        endcase
    endfunction

    // new time with a seconds update; year is deliberately odd
    task automatic tick_time(input logic [7:0] s);
        @(posedge clk);
        time_now <= '{sec: s, min: 8'h30, hour: 8'h12, date: 8'h05,
            month: 8'h06, year: 8'h99, dow: 8'h02};
        time_upd <= 1'b1;
        @(posedge clk);
        time_upd <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    // every guard code against the edges of each region; the top quarter only at 17f and 1ff
    task automatic test_guard();
        logic [8:0] al [9] = '{9'h000, 9'h03f, 9'h040, 9'h07f, 9'h080,
            9'h0ff, 9'h100, 9'h17f, 9'h180};
        for (int c = 0; c < 8; c++)
        begin
            host_model_inst.cfg(6'h10, {c[2:0], 5'h00});
            foreach (al[i])
            begin
                @(posedge clk);
                nv_wr_req <= 1'b1;
                nv_wr_addr <= al[i] + ((i == 8) ? 9'h07f : 9'h000);
                @(posedge clk);
                nv_wr_req <= 1'b0;
                @(negedge clk);
                chk(nv_wr_grant, !guarded(c[2:0], nv_wr_addr));
            end
        end
        $display("guard test ended");
    endtask

    // single event alarm: miss, match, status flags, read clear
    task automatic test_alarm();
        host_model_inst.status_done();
        host_model_inst.cfg(6'h00, 8'h95);
        host_model_inst.cfg(6'h11, 8'h20);
        tick_time(8'h14);
        chk(pin_oe_n, 1'b1);
        tick_time(8'h15);
        chk(pin_oe_n, 1'b0);
        host_model_inst.status_done();
        repeat (3) @(negedge clk);
        chk(pin_oe_n, 1'b1);
        host_model_inst.cfg(6'h11, 8'h08);
        tick_time(8'h15);
        chk(pin_oe_n, 1'b0);
        rd_val[0] = pin_o;
        repeat (2) @(negedge clk);
        chk(pin_o, !rd_val[0]);
        host_model_inst.cfg(6'h11, 8'h10);
        @(negedge clk);
        rd_val[0] = pin_o;
        repeat (16) @(negedge clk);
        chk(pin_o, !rd_val[0]);
        host_model_inst.rd(6'h3f, rd_val);
        chk(rd_val & 8'h20, 8'h20);
        $display("alarm test ended");
    endtask

    // repeat mode: alarm1 pulses the pin, pulse ends, alarm0 fires later
    task automatic test_repeat();
        int n;
        host_model_inst.cfg(6'h08, 8'ha0);
        host_model_inst.cfg(6'h11, 8'he0);
        @(negedge clk);
        chk(pin_oe_n, 1'b1);
        tick_time(8'h20);
        chk(pin_oe_n, 1'b0);
        // a pulse lasts 8192 oscillator ticks of four clocks each
        for (n = 0; n < 40000 && pin_oe_n !== 1'b1; n++)
            @(negedge clk);
        if (n >= 40000)
        begin
            err_count++;
            test_done();
        end
        chk(n > 32700 && n < 32800, 1'b1);
        tick_time(8'h15);
        chk(pin_oe_n, 1'b0);
        $display("repeat test ended");
    endtask

    // trim and supply registers seen at their outputs
    task automatic test_trim_supply();
        chk(cx_half_pf, 8'h32);
        host_model_inst.cfg(6'h12, 8'h1f);
        host_model_inst.cfg(6'h13, 8'h07);
        @(negedge clk);
        chk(cx_half_pf, 8'h51);
        chk(load_cap_code, 6'h1f);
        chk({rate_sign, rate_mag}, 3'h7);
        host_model_inst.wr(6'h13, 8'h00);
        @(negedge clk);
        chk({rate_sign, rate_mag}, 3'h7);
        host_model_inst.cfg(6'h12, 8'h20);
        host_model_inst.cfg(6'h14, 8'h83);
        @(negedge clk);
        chk(cx_half_pf, 8'h12);
        chk({switchover_policy, reset_level}, 4'h3);
        chk(serial_enable, 1'b1);
        @(posedge clk);
        on_battery <= 1'b1;
        repeat (6) @(negedge clk);
        chk(serial_enable, 1'b0);
        host_model_inst.cfg(6'h14, 8'h45);
        @(negedge clk);
        chk({reset_level_valid, reset_level}, 4'h5);
        // snapshot the stored image, spoil one byte, then restore it
        @(posedge clk);
        nv_saved <= nv_out;
        host_model_inst.cfg(6'h12, 8'h00);
        @(posedge clk);
        nv_restore <= 1'b1;
        @(posedge clk);
        nv_restore <= 1'b0;
        @(negedge clk);
        chk(load_cap_code, 6'h20);
        $display("trim and supply test ended");
    endtask

    // main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        host_model_inst.rd(6'h10, rd_val);
        chk(rd_val, 8'h18);
        test_guard();
        test_alarm();
        test_repeat();
        test_trim_supply();
        test_done();
    end

    // hang guard
    initial
    begin
        repeat (50000) @(posedge clk);
        err_count++;
        test_done();
    end
endmodule // testbench
